// File: pkg/charge_pkg.sv
// supervisor constants and encodings
package charge_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ           = 200;
  localparam int unsigned INT_PULSE_US      = 256;
  localparam int unsigned INT_PULSE_CYC     = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned CONV_PERIOD_S     = 1;
  localparam int unsigned SEC_CYC           = CONV_PERIOD_S * CLK_MHZ * 1000000;
  localparam int unsigned LOWBAT_TIMEOUT_H  = 4;
  localparam int unsigned HALF_SEC_PER_HOUR = 7200;

  // ----------------------------------------------------------------
  // analog arithmetic
  // ----------------------------------------------------------------
  localparam int unsigned WARM_DROP_MV  = 200;
  localparam int unsigned UV_PER_MV     = 1000;
  localparam int unsigned COOL_LOW_DIV  = 5;
  localparam int unsigned COOL_HIGH_DIV = 2;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] VREG_ADDR   = 8'h04;
  localparam logic [7:0] CURR_ADDR   = 8'h08;
  localparam logic [7:0] TIMER_ADDR  = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] VEFF_ADDR   = 8'h14;
  localparam logic [7:0] TCOUNT_ADDR = 8'h18;

  // ----------------------------------------------------------------
  // control word fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W     = 12;
  localparam int unsigned C_CHG_EN   = 0;
  localparam int unsigned C_TERM_EN  = 1;
  localparam int unsigned C_TIMER_EN = 2;
  localparam int unsigned C_SLOW_EN  = 3;
  localparam int unsigned C_WARM_SEL = 4;
  localparam int unsigned C_COOL_SEL = 5;
  localparam int unsigned C_TRIG     = 6;
  localparam int unsigned C_RATE     = 7;
  localparam int unsigned C_BOOST_HOT_THRESHOLD_SELECT_LO  = 8;
  localparam int unsigned C_BOOST_COLD_THRESHOLD_SELECT    = 10;
  localparam int unsigned C_BOOST_EN = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h00f;
  localparam logic [15:0] VREG_MV_RST  = 16'h1070;
  localparam logic [7:0]  CLAMP_MV_RST = 8'h00;
  localparam logic [12:0] ICHG_MA_RST  = 13'h0800;
  localparam logic [7:0]  COMP_RES_RST = 8'h00;
  localparam logic [4:0]  TIMER_H_RST  = 5'h0c;
  localparam logic [1:0]  BOOST_HOT_THRESHOLD_SELECT_OFF     = 2'b11;

  // ----------------------------------------------------------------
  // charge phase and fault codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_OFF   = 2'b00;
  localparam logic [1:0] CODE_PRE   = 2'b01;
  localparam logic [1:0] CODE_FAST  = 2'b10;
  localparam logic [1:0] CODE_DONE  = 2'b11;
  localparam logic [1:0] FAULT_NONE = 2'b00;
  localparam logic [1:0] FAULT_TMR  = 2'b11;

  typedef enum logic [2:0] {
    PH_OFF   = 3'b000,
    PH_PRE   = 3'b001,
    PH_FAST  = 3'b011,
    PH_DONE  = 3'b010,
    PH_FAULT = 3'b110
  } phase_e;

endpackage

// File: core/sec_tick.sv
// one-second tick divider
`timescale 1ns/10ps
module sec_tick #(
  parameter int unsigned CYCLES = charge_pkg::SEC_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  import charge_pkg::*;

  typedef struct packed {
    logic [27:0] cnt;
    logic        tick;
  } div_s;

  div_s s;
  div_s n;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // free running, so the conversion grid is fixed after reset
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt == 28'(CYCLES - 1)) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 28'd1;
    end
  end

  // cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule

// File: core/vreg_comp.sv
// regulation compensation and band current scaling
`timescale 1ns/10ps
module vreg_comp (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] vreg_mv,
  input  wire logic [7:0]  clamp_mv,
  input  wire logic [7:0]  comp_resistance_setting,
  input  wire logic [12:0] ichg_meas_ma,
  input  wire logic [12:0] ichg_prog_ma,
  input  wire logic        warm,
  input  wire logic        cool,
  input  wire logic        warm_voltage_select,
  input  wire logic        cool_current_select,
  output logic [25:0]      vreg_eff_uv,
  output logic [12:0]      ichg_target_ma
);
  import charge_pkg::*;

  typedef struct packed {
    logic [25:0] veff;
    logic [12:0] itgt;
  } comp_s;

  comp_s s;
  comp_s n;

  function automatic logic [25:0] min26(input logic [25:0] a, input logic [25:0] b);
    min26 = (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // mA times mOhm gives uV directly, so no divider is needed
  always_comb begin
    logic [25:0] base;
    logic [25:0] drop;
    base = 26'(vreg_mv * UV_PER_MV);
    drop = 26'(WARM_DROP_MV * UV_PER_MV);
    n = s;
    if (warm && !warm_voltage_select) begin
      base = (base > drop) ? base - drop : '0;
    end
    n.veff = 26'(base + min26(26'(ichg_meas_ma) * 26'(comp_resistance_setting),
                              26'(clamp_mv * UV_PER_MV)));
    if (cool) begin
      n.itgt = cool_current_select ? 13'(ichg_prog_ma / COOL_HIGH_DIV)
                                   : 13'(ichg_prog_ma / COOL_LOW_DIV);
    end else begin
      n.itgt = ichg_prog_ma;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign vreg_eff_uv    = s.veff;
  assign ichg_target_ma = s.itgt;
endmodule

// File: core/charge_supervisor.sv
// charge cycle supervisor top
`timescale 1ns/10ps

// Notes on behaviour
// - end: above recharge, below termination current
// - switch off at done; may close for supplement
// - termination: code 11, interrupt
// - no termination in regulation
// - termination enable 0 blocks it
// - programmed + min(current x resistance, clamp)
// - charge only inside window
// - warm, select 0: minus 200 mV
// - cool: 20% or 50% current
// - boost window unless hot select 11
// - boost off outside window
// - 4 h below low battery, else programmed
// - expiry: fault 11, interrupt
// - timer enable 0 stops timer
// - half rate in regulation
// - slowdown 0 keeps full rate
// - trigger: one conversion, set until done, 1 s
// - rate 1: each second, trigger held
// - battery only: above minimum system
// - bat, sys, therm always; input off battery only; current charging
// - power good needs all five conditions
// - code 00 off, 01 pre, 10 fast, 11 done
// - one 256 us pulse per event
// - done, below recharge: new cycle
module charge_supervisor #(
  parameter int unsigned SEC_CYCLES = charge_pkg::SEC_CYC,
  parameter int unsigned INT_CYCLES = charge_pkg::INT_PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        vbat_above_recharge,
  input  wire logic        vbat_below_fast,
  input  wire logic        vbat_below_lowv,
  input  wire logic        ichg_below_term,
  input  wire logic [12:0] ichg_meas_ma,
  input  wire logic        input_current_reg_flag,
  input  wire logic        input_voltage_reg_flag,
  input  wire logic        thermal_reg_flag,
  input  wire logic        sys_below_bat,
  input  wire logic        thermistor_cold,
  input  wire logic        thermistor_cool,
  input  wire logic        thermistor_warm,
  input  wire logic        thermistor_hot,
  input  wire logic [1:0]  thermistor_boost_cold,
  input  wire logic [2:0]  thermistor_boost_hot,
  input  wire logic        battery_only,
  input  wire logic        vbat_above_min_system,
  input  wire logic        vbus_above_uvlo,
  input  wire logic        vbus_above_bat,
  input  wire logic        vbus_below_ovp,
  input  wire logic        vbus_above_min_loaded,
  input  wire logic        source_detect_done,
  output logic             charge_run,
  output logic             battery_switch,
  output logic             boost_run,
  output logic [25:0]      vreg_eff_uv,
  output logic [12:0]      ichg_target_ma,
  output logic             monitor_on,
  output logic             adc_sample,
  output logic [4:0]       adc_channels,
  output logic             host_int_n,
  output logic             power_good_n
);
  import charge_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       vreg_mv;
    logic [7:0]        clamp_mv;
    logic [12:0]       ichg_ma;
    logic [7:0]        comp_res;
    logic [4:0]        timer_h;
    phase_e            phase;
    logic [1:0]        fault;
    logic [17:0]       tmr;
    logic [15:0]       int_cnt;
    logic              int_n;
    logic              run;
    logic              bsw;
    logic              boost;
    logic              mon;
    logic              sample;
    logic [4:0]        chan;
    logic              good_n;
    logic              ack;
    logic [31:0]       rdata;
  } sup_s;

  sup_s        s;
  sup_s        n;
  logic        tick;
  logic [25:0] veff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic [1:0] code_of(input phase_e p);
    case (p)
      PH_PRE:  code_of = CODE_PRE;
      PH_FAST: code_of = CODE_FAST;
      PH_DONE: code_of = CODE_DONE;
      default: code_of = CODE_OFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  sec_tick #(
    .CYCLES(SEC_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  vreg_comp u_comp (
    .clk                     (clk),
    .rst                     (rst),
    .vreg_mv                 (s.vreg_mv),
    .clamp_mv                (s.clamp_mv),
    .comp_resistance_setting (s.comp_res),
    .ichg_meas_ma            (ichg_meas_ma),
    .ichg_prog_ma            (s.ichg_ma),
    .warm                    (thermistor_warm),
    .cool                    (thermistor_cool),
    .warm_voltage_select     (s.ctrl[C_WARM_SEL]),
    .cool_current_select     (s.ctrl[C_COOL_SEL]),
    .vreg_eff_uv             (veff),
    .ichg_target_ma          (ichg_target_ma)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        req;
    logic        evt;
    logic        any_reg;
    logic        suspend;
    logic        chg_en;
    logic        allow;
    logic        boost_cold_threshold_select;
    logic        boost_hot_threshold_select;
    logic        trig;
    logic [17:0] lim;
    logic [31:0] w;
    req     = wb_cyc_i & wb_stb_i & ~s.ack;
    evt     = 1'b0;
    any_reg = input_current_reg_flag | input_voltage_reg_flag | thermal_reg_flag;
    suspend = thermistor_cold | thermistor_hot;
    chg_en  = s.ctrl[C_CHG_EN] & (s.ichg_ma != '0);
    allow   = ~battery_only | vbat_above_min_system;
    boost_cold_threshold_select   = thermistor_boost_cold[s.ctrl[C_BOOST_COLD_THRESHOLD_SELECT]];
    boost_hot_threshold_select    = 1'b0;
    trig    = 1'b0;
    w       = '0;
    lim     = vbat_below_lowv ? 18'(LOWBAT_TIMEOUT_H * HALF_SEC_PER_HOUR)
                              : 18'(s.timer_h * HALF_SEC_PER_HOUR);
    n        = s;
    n.ack    = req;
    n.sample = 1'b0;

    // charge phase sequencing
    case (s.phase)
      PH_OFF: begin
        if (chg_en) begin
          n.phase = vbat_below_fast ? PH_PRE : PH_FAST;
          n.tmr   = '0;
        end
      end
      PH_PRE: begin
        if (!vbat_below_fast) begin
          n.phase = PH_FAST;
        end
      end
      PH_FAST: begin
        // regulation starves the current, so a low reading is not a full cell
        if (vbat_above_recharge && ichg_below_term && !any_reg
            && s.ctrl[C_TERM_EN] && !suspend) begin
          n.phase = PH_DONE;
          evt     = 1'b1;
        end
      end
      PH_DONE: begin
        if (!vbat_above_recharge) begin
          n.phase = vbat_below_fast ? PH_PRE : PH_FAST;
          n.tmr   = '0;
        end
      end
      PH_FAULT: begin
        n.phase = PH_FAULT; // held until charging is disabled
      end
      default: begin
        n.phase = PH_OFF;
      end
    endcase

    // half seconds: +2 full rate, +1 half
    if (!s.ctrl[C_TIMER_EN]) begin
      n.tmr = '0;
    end else if ((s.phase == PH_PRE || s.phase == PH_FAST) && n.phase != PH_DONE) begin
      if (s.tmr >= lim) begin
        n.phase = PH_FAULT;
        n.fault = FAULT_TMR;
        evt     = 1'b1;
      end else if (tick && !suspend) begin
        n.tmr = (s.ctrl[C_SLOW_EN] && any_reg) ? s.tmr + 18'd1
                                               : s.tmr + 18'd2;
      end
    end
    if (!chg_en) begin
      n.phase = PH_OFF;
    end

    // boost window; hot select 11 skips it
    case (s.ctrl[C_BOOST_HOT_THRESHOLD_SELECT_LO +: 2])
      2'b00:   boost_hot_threshold_select = thermistor_boost_hot[0];
      2'b01:   boost_hot_threshold_select = thermistor_boost_hot[1];
      2'b10:   boost_hot_threshold_select = thermistor_boost_hot[2];
      default: boost_hot_threshold_select = 1'b0;
    endcase
    n.boost = s.ctrl[C_BOOST_EN] & ((s.ctrl[C_BOOST_HOT_THRESHOLD_SELECT_LO +: 2] == BOOST_HOT_THRESHOLD_SELECT_OFF)
                                    | (~boost_cold_threshold_select & ~boost_hot_threshold_select));

    // monitor; one-shot ends at next tick that allows a conversion
    if (s.ctrl[C_RATE]) begin
      n.ctrl[C_TRIG] = 1'b1;
    end
    if (tick && allow && s.ctrl[C_TRIG]) begin
      n.sample = 1'b1;
      n.chan   = {(s.phase == PH_PRE || s.phase == PH_FAST), ~battery_only,
                  3'b111};
      if (!s.ctrl[C_RATE]) begin
        n.ctrl[C_TRIG] = 1'b0;
      end
    end
    n.mon = n.ctrl[C_TRIG] & allow;

    // status read clears the fault code; a new expiry in that cycle wins only if the code was 00
    if (req && !wb_we_i && wb_adr_i == STATUS_ADDR && n.fault == s.fault) begin
      n.fault = FAULT_NONE;
    end

    // writes; trigger only sets, device or a rate 1-to-0 write clears
    if (req && wb_we_i) begin
      if (wb_adr_i == CTRL_ADDR) begin
        trig   = n.ctrl[C_TRIG] | (wb_dat_i[C_TRIG] & wb_sel_i[0]);
        w      = merge({20'h0, s.ctrl}, wb_dat_i, wb_sel_i);
        n.ctrl = w[CTRL_W-1:0];
        n.ctrl[C_TRIG] = trig;
        if (s.ctrl[C_RATE] && !w[C_RATE]) begin
          n.ctrl[C_TRIG] = 1'b0;
        end else if (w[C_RATE]) begin
          n.ctrl[C_TRIG] = 1'b1;
        end
      end else if (wb_adr_i == VREG_ADDR) begin
        w          = merge({8'h0, s.clamp_mv, s.vreg_mv}, wb_dat_i, wb_sel_i);
        n.vreg_mv  = w[15:0];
        n.clamp_mv = w[23:16];
      end else if (wb_adr_i == CURR_ADDR) begin
        w          = merge({8'h0, s.comp_res, 3'h0, s.ichg_ma}, wb_dat_i, wb_sel_i);
        n.ichg_ma  = w[12:0];
        n.comp_res = w[23:16];
      end else if (wb_adr_i == TIMER_ADDR) begin
        w         = merge({27'h0, s.timer_h}, wb_dat_i, wb_sel_i);
        n.timer_h = w[4:0];
      end
    end

    // reads; unmapped read zero
    if (req && !wb_we_i) begin
      if (wb_adr_i == CTRL_ADDR) begin
        n.rdata = {20'h0, s.ctrl};
      end else if (wb_adr_i == VREG_ADDR) begin
        n.rdata = {8'h0, s.clamp_mv, s.vreg_mv};
      end else if (wb_adr_i == CURR_ADDR) begin
        n.rdata = {8'h0, s.comp_res, 3'h0, s.ichg_ma};
      end else if (wb_adr_i == TIMER_ADDR) begin
        n.rdata = {27'h0, s.timer_h};
      end else if (wb_adr_i == STATUS_ADDR) begin
        n.rdata = {23'h0, suspend, ~s.good_n, s.mon, s.boost, s.bsw,
                   s.fault, code_of(s.phase)};
      end else if (wb_adr_i == VEFF_ADDR) begin
        n.rdata = {6'h0, veff};
      end else if (wb_adr_i == TCOUNT_ADDR) begin
        n.rdata = {14'h0, s.tmr};
      end else begin
        n.rdata = '0;
      end
    end

    // new event restarts the width
    if (evt) begin
      n.int_cnt = 16'(INT_CYCLES);
    end else if (s.int_cnt != '0) begin
      n.int_cnt = s.int_cnt - 16'd1;
    end
    n.int_n = (n.int_cnt == '0);

    // run and switch outputs follow the new phase; power good follows the vbus inputs
    n.run    = (n.phase == PH_PRE || n.phase == PH_FAST) && !suspend;
    n.bsw    = (n.phase != PH_DONE) || sys_below_bat;
    n.good_n = ~(vbus_above_uvlo & vbus_above_bat & vbus_below_ovp
                 & vbus_above_min_loaded & source_detect_done);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s          <= '0;
      s.ctrl     <= CTRL_RST;
      s.vreg_mv  <= VREG_MV_RST;
      s.clamp_mv <= CLAMP_MV_RST;
      s.ichg_ma  <= ICHG_MA_RST;
      s.comp_res <= COMP_RES_RST;
      s.timer_h  <= TIMER_H_RST;
      s.phase    <= PH_OFF;
      s.int_n    <= 1'b1;
      s.bsw      <= 1'b1;
      s.good_n   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o       = s.rdata;
  assign wb_ack_o       = s.ack;
  assign charge_run     = s.run;
  assign battery_switch = s.bsw;
  assign boost_run      = s.boost;
  assign vreg_eff_uv    = veff;
  assign monitor_on     = s.mon;
  assign adc_sample     = s.sample;
  assign adc_channels   = s.chan;
  assign host_int_n     = s.int_n;
  assign power_good_n   = s.good_n;
endmodule

// File: test/charge_supervisor_monitor.sv
// supervisor assertions
`timescale 1ns/10ps
module charge_supervisor_monitor #(
  parameter int unsigned INT_CYCLES = 16
) (
  input wire logic       clk, rst, wb_cyc_i, wb_stb_i, wb_ack_o, vbat_above_recharge,
  input wire logic       ichg_below_term, input_current_reg_flag, input_voltage_reg_flag,
  input wire logic       thermal_reg_flag, thermistor_cold, thermistor_hot, battery_only,
  input wire logic       vbat_above_min_system, vbus_above_uvlo, vbus_above_bat,
  input wire logic       vbus_below_ovp, vbus_above_min_loaded, source_detect_done,
  input wire logic       battery_switch, charge_run, host_int_n, power_good_n, adc_sample,
  input wire logic [4:0] adc_channels
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [15:0] low_cnt;
  wire         regl  = input_current_reg_flag | input_voltage_reg_flag | thermal_reg_flag;
  wire         pg_ok = vbus_above_uvlo & vbus_above_bat & vbus_below_ovp
                       & vbus_above_min_loaded & source_detect_done;
  // too long to repeat, so count low cycles
  always_ff @(posedge clk) low_cnt <= (rst | host_int_n) ? 16'h0000 : low_cnt + 16'h0001;

  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_int_len; $rose(host_int_n) |-> low_cnt == INT_CYCLES; endproperty
  a_int_len: assert property (p_int_len) else $error("int width");
  property p_term_cause;
    $fell(battery_switch) |-> $past(vbat_above_recharge && ichg_below_term && !regl);
  endproperty
  a_term_cause: assert property (p_term_cause) else $error("end without cause");
  property p_term_int; $fell(battery_switch) |-> !host_int_n && !charge_run; endproperty
  a_term_int: assert property (p_term_int) else $error("done without int");
  property p_pg; !$past(rst) |=> power_good_n == !$past(pg_ok); endproperty
  a_pg: assert property (p_pg) else $error("power good");
  property p_suspend; thermistor_cold || thermistor_hot |=> !charge_run; endproperty
  a_suspend: assert property (p_suspend) else $error("run in suspend");
  property p_chan; adc_sample |-> adc_channels[2:0] == 3'b111; endproperty
  a_chan: assert property (p_chan) else $error("channels");
  property p_no_conv; (battery_only && !vbat_above_min_system) [*2] |-> !adc_sample; endproperty
  a_no_conv: assert property (p_no_conv) else $error("conv on low bat");
  c_term: cover property ($fell(battery_switch));
  c_conv: cover property (adc_sample);
  c_pg: cover property ($fell(power_good_n));
endmodule

bind charge_supervisor charge_supervisor_monitor #(.INT_CYCLES(INT_CYCLES)) u_mon (.*);

// File: test/host_model.sv
// wishbone host model
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdata
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial begin
    {cyc, stb, we, adr, sel, wdata} = '0;
  end
  // held until ack; released data scrambled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdata} <= {1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdata;
    {cyc, stb, we, wdata} <= {3'b000, ~d};
  endtask
endmodule

// File: test/tb_top.sv
// supervisor bench
`timescale 1ns/10ps
module tb_top;
  import charge_pkg::*;
  localparam int unsigned SEC_N = 10;
  localparam int unsigned INT_N = 16;
  logic clk = 1'b0, rst = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic vbat_above_recharge, vbat_below_fast, vbat_below_lowv, ichg_below_term;
  logic input_current_reg_flag, input_voltage_reg_flag, thermal_reg_flag, sys_below_bat;
  logic thermistor_cold, thermistor_cool, thermistor_warm, thermistor_hot, battery_only;
  logic vbat_above_min_system, vbus_above_uvlo, vbus_above_bat, vbus_below_ovp;
  logic vbus_above_min_loaded, source_detect_done, charge_run, battery_switch, boost_run;
  logic monitor_on, adc_sample, host_int_n, power_good_n;
  logic [12:0] ichg_meas_ma, ichg_target_ma;
  logic [1:0] thermistor_boost_cold;
  logic [2:0] thermistor_boost_hot;
  logic [25:0] vreg_eff_uv;
  logic [4:0] adc_channels;
  logic [7:0] ra[$] = '{CTRL_ADDR, VREG_ADDR, CURR_ADDR, TIMER_ADDR, 8'h1c};
  logic [31:0] rv[$] = '{32'h00f, 32'h1070, 32'h800, 32'h0c, 32'h0};
  int n_mismatch = 0, samples_checked = 0, i, k, r;

  charge_supervisor #(.SEC_CYCLES(SEC_N), .INT_CYCLES(INT_N)) u_dut (.*);
  host_model u_host (.clk(clk), .ack(wb_ack_o), .rdata(wb_dat_o), .cyc(wb_cyc_i),
    .stb(wb_stb_i), .we(wb_we_i), .adr(wb_adr_i), .sel(wb_sel_i), .wdata(wb_dat_i));

  // ----------------------------------------
  // reference model and checking
  // ----------------------------------------
  // programmed 4208 mV, clamp 100 mV, 20 mOhm; result in uV
  function automatic int m_veff(int im, bit w);
    return (4208 - (w ? 200 : 0)) * 1000 + ((im * 20 < 100000) ? im * 20 : 100000);
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic ph(logic [1:0] e);
    rd(STATUS_ADDR);
    chk("phase", e, q[1:0]);
  endtask
  task automatic tr(logic e);
    rd(CTRL_ADDR);
    chk("trig", e, q[6]);
  endtask
  task automatic tk(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic await(ref logic s, input logic v, input int lim);
    i = 0;
    while (s !== v && i < lim) begin
      @(posedge clk);
      i++;
    end
  endtask

  initial begin
    forever #2.5 clk = ~clk;
  end
  // hang guard, well past the timer run
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {vbat_above_recharge, vbat_below_lowv, ichg_below_term, input_current_reg_flag,
     input_voltage_reg_flag, thermal_reg_flag, sys_below_bat, thermistor_cold, thermistor_cool,
     thermistor_warm, thermistor_hot, battery_only, vbus_above_uvlo, vbus_above_bat,
     vbus_below_ovp, vbus_above_min_loaded, source_detect_done, thermistor_boost_cold,
     thermistor_boost_hot, ichg_meas_ma} = '0;
    {vbat_below_fast, vbat_above_min_system} = 2'b11;
    void'($urandom(32'h85e14b6c));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[j]) begin
      rd(ra[j]);
      chk("reg", rv[j], q);
    end
    ph(2'h1);
    vbat_below_fast <= 1'b0;
    wr(CTRL_ADDR, 32'h80f);
    for (k = 0; k < 12; k++) begin
      i = (k % 3 == 0) ? 31 : $urandom_range(30, 0);
      r = $urandom;
      @(posedge clk);
      {vbus_above_uvlo, vbus_above_bat, vbus_below_ovp, vbus_above_min_loaded,
       source_detect_done} <= 5'(i);
      {thermistor_boost_cold, thermistor_boost_hot} <= 5'(r);
      tk(2);
      chk("pg_n", i != 31, power_good_n);
      chk("boost", !(r[3] | r[0]), boost_run);
    end
    // termination waits for regulation to clear
    ph(2'h2);
    {input_current_reg_flag, input_voltage_reg_flag, thermal_reg_flag} <=
      3'($urandom_range(7, 1));
    {vbat_above_recharge, ichg_below_term} <= 2'b11;
    repeat (4) @(posedge clk);
    ph(2'h2);
    {input_current_reg_flag, input_voltage_reg_flag, thermal_reg_flag} <= 3'b000;
    tk(1);
    chk("switch_int", 32'h0, {battery_switch, host_int_n, charge_run});
    ph(2'h3);
    {vbat_above_recharge, ichg_below_term} <= 2'b00;
    repeat (30) @(posedge clk);
    ph(2'h2);
    wr(CTRL_ADDR, 32'h00d);
    {vbat_above_recharge, ichg_below_term} <= 2'b11;
    repeat (4) @(posedge clk);
    ph(2'h2);
    {vbat_above_recharge, ichg_below_term, thermistor_hot} <= 3'b001;
    tk(2);
    chk("run", 32'h0, charge_run);
    @(posedge clk);
    thermistor_hot <= 1'b0;
    tk(2);
    chk("run", 32'h1, charge_run);
    // modest clamp and resistance keep the level safe
    wr(VREG_ADDR, 32'h0064_1070);
    wr(CURR_ADDR, 32'h0014_0800);
    for (k = 0; k < 8; k++) begin
      wr(CTRL_ADDR, {26'h0, k[2], 5'h0f});
      i = $urandom_range(8191, 0);
      {ichg_meas_ma, thermistor_warm, thermistor_cool} <= {13'(i), k[0], k[1] & ~k[0]};
      tk(3);
      chk("veff", m_veff(i, k[0]), vreg_eff_uv);
      chk("itarget", (k[1] & ~k[0]) ? 2048 / (k[2] ? 2 : 5) : 2048, ichg_target_ma);
    end
    wr(CTRL_ADDR, 32'h04f);
    {thermistor_warm, thermistor_cool} <= 2'b00;
    await(adc_sample, 1'b1, 3 * SEC_N);
    chk("sample_chan", 32'h3f, {adc_sample, adc_channels});
    tr(1'b0);
    wr(CTRL_ADDR, 32'h08f);
    repeat (2 * SEC_N) @(posedge clk);
    k = 0;
    repeat (5 * SEC_N) begin
      @(posedge clk);
      k += (adc_sample === 1'b1);
    end
    chk("samples", 32'h5, k);
    chk("mon", 32'h1, monitor_on);
    tr(1'b1);
    wr(CTRL_ADDR, 32'h00f);
    tr(1'b0);
    // one programmed hour: 7200 half-seconds at two per tick
    wr(TIMER_ADDR, 32'h01);
    await(host_int_n, 1'b0, 40000);
    rd(STATUS_ADDR);
    chk("status", 32'hc, q[3:0]);
    {battery_only, vbat_above_min_system} <= 2'b10;
    wr(CTRL_ADDR, 32'h04f);
    repeat (3 * SEC_N) @(posedge clk);
    tr(1'b1);
    chk("mon", 32'h0, monitor_on);
    end_of_test();
  end
endmodule
